// *** common/mf_pkg.sv ***
`default_nettype none
package mf_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int SCR_W = 15;
	localparam int LANES = 4;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 7;
	localparam logic [6:0] IDX_RESET_MASK = 7'h02;
	localparam logic [6:0] IDX_MF_CTRL = 7'h03;
	localparam logic [6:0] IDX_SCRAMBLE = 7'h05;
	localparam logic [6:0] IDX_MF_LEN = 7'h06;
	localparam logic [6:0] IDX_SUBCLASS = 7'h07;
	localparam logic [6:0] IDX_MAP_A = 7'h31;
	localparam logic [6:0] IDX_MAP_B = 7'h32;
	localparam logic [6:0] IDX_STATUS = 7'h40;
	localparam logic [6:0] IDX_DEEMPH [LANES] = '{7'h13, 7'h12, 7'h14, 7'h15};
	localparam int FORCE_BIT = 7;
	localparam int START_LSB = 2;
	localparam int START_MSB = 6;
	localparam int DELAY_MSB = 1;
	localparam int IGNORE_BIT = 3;
	localparam int SCRAMBLE_BIT = 7;
	localparam int SUBCLASS_BIT = 3;
	localparam int K_MSB = 4;
	localparam int DEEMPH_LSB = 2;
	localparam int DEEMPH_MSB = 7;
	localparam int STAT_FC_LSB = 8;
	localparam int STAT_ST_LSB = 16;
	localparam logic [7:0] RST_MF_CTRL = 8'h00;
	localparam logic RST_IGNORE = 1'b0;
	localparam logic RST_SCRAMBLE = 1'b0;
	localparam logic [4:0] RST_K = 5'h08;
	localparam logic RST_SUBCLASS = 1'b1;
	localparam logic [5:0] RST_DEEMPH = 6'h00;
	localparam logic [7:0] RST_MAP = 8'h00;
	localparam logic [7:0] MAP_DEFAULT = 8'h00;
	localparam logic [7:0] MAP_IDENTITY = 8'hE4;
	localparam logic [4:0] LMFC_RELEASE_COUNT = 5'h1F;
	localparam logic [1:0] ILAS_LAST = 2'h3;
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {ST_CGS, ST_WAIT_COUNT, ST_DELAY, ST_ILAS, ST_DATA} link_state_t;

	// Self-synchronous scrambler 1 + x^14 + x^15, MSB first
	function automatic logic [30:0] scramble(input logic [15:0] d, input logic [14:0] s);
		logic [14:0] st;
		logic [15:0] o;
		logic b;
		st = s;
		o = '0;
		b = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			b = d[i] ^ st[14] ^ st[13];
			o[i] = b;
			st = {st[13:0], b};
		end
		return {o, st};
	endfunction
endpackage
`default_nettype wire

// *** common/cfg_if.sv ***
`default_nettype none
interface cfg_if;
	import mf_pkg::*;
	logic force_start;
	logic [4:0] start_value;
	logic [1:0] release_delay;
	logic reset_ignore;
	logic scrambler_on;
	logic [4:0] k_minus1;
	logic subclass1;
	logic [4:0] mf_count;
	logic [4:0] frame_count;
	link_state_t link_state;
	modport ctrl (output force_start, start_value, release_delay, reset_ignore, scrambler_on,
		k_minus1, subclass1, input mf_count, frame_count, link_state);
	modport align (input force_start, start_value, release_delay, reset_ignore, scrambler_on,
		k_minus1, subclass1, output mf_count, frame_count, link_state);
endinterface
`default_nettype wire

// *** verilog/mf_align_core.sv ***
`default_nettype none
module mf_align_core
	import mf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	cfg_if.align cfg,
	input wire logic sysref,
	input wire logic sync_n,
	input wire logic frame_strobe,
	input wire logic [DATA_W-1:0] sample_data,
	output logic [DATA_W-1:0] lane_data,
	output logic k28_5_active,
	output logic ilas_active,
	output logic data_active,
	output logic mf_boundary
);
	logic [4:0] fc_reg;
	logic [4:0] mf_reg;
	logic sysref_d_reg;
	link_state_t state_reg, state_next;
	logic [1:0] wait_reg, wait_next;
	logic [SCR_W-1:0] scr_reg;

	// Counter reset requests
	wire sysref_rise = sysref && !sysref_d_reg;
	wire sysref_take = sysref_rise && cfg.subclass1 && !cfg.reset_ignore;
	wire [4:0] mf_load = cfg.force_start ? cfg.start_value : 5'h00;
	wire mf_wrap = frame_strobe && (fc_reg >= cfg.k_minus1);
	wire [4:0] mf_inc = mf_reg + 5'h01;
	wire hit_release = mf_wrap && (mf_inc == LMFC_RELEASE_COUNT);
	wire [30:0] scr_word = scramble(sample_data, scr_reg);
	wire send_k = (state_next == ST_CGS) || (state_next == ST_WAIT_COUNT);

	assign cfg.mf_count = mf_reg;
	assign cfg.frame_count = fc_reg;
	assign cfg.link_state = state_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fc_reg <= 5'h00;
			mf_reg <= 5'h00;
			sysref_d_reg <= 1'b0;
		end else begin
			sysref_d_reg <= sysref;
			if (sysref_take) begin
				fc_reg <= 5'h00;
				mf_reg <= mf_load;
			end else if (frame_strobe) begin
				fc_reg <= mf_wrap ? 5'h00 : fc_reg + 5'h01;
				if (mf_wrap) begin
					mf_reg <= mf_inc;
				end
			end
		end
	end

	// Link start-up sequence
	always_comb begin
		state_next = state_reg;
		wait_next = wait_reg;
		case (state_reg)
			ST_CGS: begin
				if (sync_n) begin
					state_next = ST_WAIT_COUNT;
				end
			end
			ST_WAIT_COUNT: begin
				if (hit_release) begin
					if (cfg.release_delay == 2'h0) begin
						state_next = ST_ILAS;
						wait_next = ILAS_LAST;
					end else begin
						state_next = ST_DELAY;
						wait_next = cfg.release_delay - 2'h1;
					end
				end
			end
			ST_DELAY: begin
				if (mf_wrap) begin
					if (wait_reg == 2'h0) begin
						state_next = ST_ILAS;
						wait_next = ILAS_LAST;
					end else begin
						wait_next = wait_reg - 2'h1;
					end
				end
			end
			ST_ILAS: begin
				if (mf_wrap) begin
					if (wait_reg == 2'h0) begin
						state_next = ST_DATA;
					end else begin
						wait_next = wait_reg - 2'h1;
					end
				end
			end
			ST_DATA: state_next = ST_DATA;
			default: state_next = ST_CGS;
		endcase
		if (!sync_n) begin
			state_next = ST_CGS;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_CGS;
			wait_reg <= 2'h0;
			k28_5_active <= 1'b1;
			ilas_active <= 1'b0;
			data_active <= 1'b0;
			mf_boundary <= 1'b0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			k28_5_active <= send_k;
			ilas_active <= state_next == ST_ILAS;
			data_active <= state_next == ST_DATA;
			mf_boundary <= mf_wrap && !sysref_take;
		end
	end

	// Lane data per frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lane_data <= {K28_5, K28_5};
			scr_reg <= '0;
		end else if (frame_strobe) begin
			if (send_k) begin
				lane_data <= {K28_5, K28_5};
			end else if ((state_next == ST_DATA) && cfg.scrambler_on) begin
				lane_data <= scr_word[30:15];
				scr_reg <= scr_word[14:0];
			end else begin
				lane_data <= sample_data;
			end
		end
	end
endmodule // mf_align_core
`default_nettype wire

// *** verilog/serial_link_multiframe_control.sv ***
`default_nettype none
module serial_link_multiframe_control
	import mf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sysref,
	input wire logic sync_n,
	input wire logic frame_strobe,
	input wire logic decimate_by2,
	input wire logic [DATA_W-1:0] sample_data,
	output logic [DATA_W-1:0] lane_data,
	output logic k28_5_active,
	output logic ilas_active,
	output logic data_active,
	output logic mf_boundary,
	output logic scrambler_on,
	output logic subclass1,
	output logic [7:0] chan_a_lane_map,
	output logic [7:0] chan_b_lane_map,
	output logic [LANES*6-1:0] lane_deemphasis_sel
);
	// Address decode shared by read and write
	function automatic logic idx_known(input logic [IDX_W-1:0] idx);
		logic hit;
		hit = (idx == IDX_RESET_MASK) || (idx == IDX_MF_CTRL) || (idx == IDX_SCRAMBLE)
			|| (idx == IDX_MF_LEN) || (idx == IDX_SUBCLASS) || (idx == IDX_MAP_A)
			|| (idx == IDX_MAP_B) || (idx == IDX_STATUS);
		for (int l = 0; l < LANES; l++) begin
			hit = hit || (idx == IDX_DEEMPH[l]);
		end
		return hit;
	endfunction

	// Default routing or four distinct two-bit lane selections
	function automatic logic map_supported(input logic [7:0] m);
		return (m == MAP_DEFAULT) || ((m[1:0] != m[3:2]) && (m[1:0] != m[5:4])
			&& (m[1:0] != m[7:6]) && (m[3:2] != m[5:4]) && (m[3:2] != m[7:6])
			&& (m[5:4] != m[7:6]));
	endfunction

	function automatic logic [7:0] map_applied(input logic [7:0] m, input logic dec);
		return (dec && (m != MAP_DEFAULT)) ? m : MAP_IDENTITY;
	endfunction

	function automatic logic is_thermo(input logic [5:0] x);
		return (x & (x + 6'h01)) == 6'h00;
	endfunction

	cfg_if cfg ();

	logic aw_free_reg;
	logic w_free_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;
	logic [7:0] mf_ctrl_reg;
	logic ignore_reg;
	logic scramble_reg;
	logic [4:0] k_reg;
	logic subclass_reg;
	logic [7:0] map_a_reg;
	logic [7:0] map_b_reg;
	logic [5:0] deemph_reg [LANES];

	// Write path decode
	wire [IDX_W-1:0] w_idx = awaddr_reg[IDX_LSB +: IDX_W];
	wire wr_fire = !aw_free_reg && !w_free_reg && !bvalid;
	wire wr_known = idx_known(w_idx);
	wire wr_en = wr_fire && wr_known && wstrb0_reg;
	wire [7:0] wbyte = wdata_reg[7:0];
	wire wr_mf_ctrl = wr_en && (w_idx == IDX_MF_CTRL);
	wire wr_mask = wr_en && (w_idx == IDX_RESET_MASK);
	wire wr_scramble = wr_en && (w_idx == IDX_SCRAMBLE);
	wire wr_k = wr_en && (w_idx == IDX_MF_LEN);
	wire wr_subclass = wr_en && (w_idx == IDX_SUBCLASS);
	wire wr_map_a = wr_en && (w_idx == IDX_MAP_A) && map_supported(wbyte);
	wire wr_map_b = wr_en && (w_idx == IDX_MAP_B) && map_supported(wbyte);

	// Read path decode
	wire [IDX_W-1:0] r_idx = araddr[IDX_LSB +: IDX_W];
	wire rd_known = idx_known(r_idx);
	wire [31:0] status_word = {13'h0000, cfg.link_state, 3'h0, cfg.frame_count, 3'h0,
		cfg.mf_count};
	wire [31:0] deemph_word = (r_idx == IDX_DEEMPH[0]) ? {24'h0, deemph_reg[0], 2'h0}
		: (r_idx == IDX_DEEMPH[1]) ? {24'h0, deemph_reg[1], 2'h0}
		: (r_idx == IDX_DEEMPH[2]) ? {24'h0, deemph_reg[2], 2'h0}
		: (r_idx == IDX_DEEMPH[3]) ? {24'h0, deemph_reg[3], 2'h0} : 32'h0;
	wire [31:0] rd_word = (r_idx == IDX_MF_CTRL) ? {24'h0, mf_ctrl_reg}
		: (r_idx == IDX_RESET_MASK) ? {28'h0, ignore_reg, 3'h0}
		: (r_idx == IDX_SCRAMBLE) ? {24'h0, scramble_reg, 7'h00}
		: (r_idx == IDX_MF_LEN) ? {27'h0, k_reg}
		: (r_idx == IDX_SUBCLASS) ? {28'h0, subclass_reg, 3'h0}
		: (r_idx == IDX_MAP_A) ? {24'h0, map_a_reg}
		: (r_idx == IDX_MAP_B) ? {24'h0, map_b_reg}
		: (r_idx == IDX_STATUS) ? status_word : deemph_word;

	// Configuration towards the alignment core
	assign cfg.force_start = mf_ctrl_reg[FORCE_BIT];
	assign cfg.start_value = mf_ctrl_reg[START_MSB:START_LSB];
	assign cfg.release_delay = mf_ctrl_reg[DELAY_MSB:0];
	assign cfg.reset_ignore = ignore_reg;
	assign cfg.scrambler_on = scramble_reg;
	assign cfg.k_minus1 = k_reg;
	assign cfg.subclass1 = subclass_reg;

	assign scrambler_on = scramble_reg;
	assign subclass1 = subclass_reg;

	// Write address and data channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_free_reg <= 1'b1;
			awaddr_reg <= '0;
		end else if (awvalid && aw_free_reg) begin
			aw_free_reg <= 1'b0;
			awaddr_reg <= awaddr;
		end else if (bvalid && bready) begin
			aw_free_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_free_reg <= 1'b1;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
		end else if (wvalid && w_free_reg) begin
			w_free_reg <= 1'b0;
			wdata_reg <= wdata;
			wstrb0_reg <= wstrb[0];
		end else if (bvalid && bready) begin
			w_free_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
		end else begin
			awready <= aw_free_reg ? !awvalid : (bvalid && bready);
			wready <= w_free_reg ? !wvalid : (bvalid && bready);
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_known ? rd_word : 32'h0;
			rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mf_ctrl_reg <= RST_MF_CTRL;
			ignore_reg <= RST_IGNORE;
			scramble_reg <= RST_SCRAMBLE;
		end else begin
			if (wr_mf_ctrl) begin
				mf_ctrl_reg <= wbyte;
			end
			if (wr_mask) begin
				ignore_reg <= wbyte[IGNORE_BIT];
			end
			if (wr_scramble) begin
				scramble_reg <= wbyte[SCRAMBLE_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			k_reg <= RST_K;
			subclass_reg <= RST_SUBCLASS;
			map_a_reg <= RST_MAP;
			map_b_reg <= RST_MAP;
		end else begin
			if (wr_k) begin
				k_reg <= wbyte[K_MSB:0];
			end
			if (wr_subclass) begin
				subclass_reg <= wbyte[SUBCLASS_BIT];
			end
			if (wr_map_a) begin
				map_a_reg <= wbyte;
			end
			if (wr_map_b) begin
				map_b_reg <= wbyte;
			end
		end
	end

	// Per-lane de-emphasis selectors
	for (genvar l = 0; l < LANES; l++) begin : g_deemph
		wire wr_lane = wr_en && (w_idx == IDX_DEEMPH[l])
			&& is_thermo(wbyte[DEEMPH_MSB:DEEMPH_LSB]);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				deemph_reg[l] <= RST_DEEMPH;
			end else if (wr_lane) begin
				deemph_reg[l] <= wbyte[DEEMPH_MSB:DEEMPH_LSB];
			end
		end
		assign lane_deemphasis_sel[l*6 +: 6] = deemph_reg[l];
	end

	// Stream-to-lane routing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_a_lane_map <= MAP_IDENTITY;
			chan_b_lane_map <= MAP_IDENTITY;
		end else begin
			chan_a_lane_map <= map_applied(map_a_reg, decimate_by2);
			chan_b_lane_map <= map_applied(map_b_reg, decimate_by2);
		end
	end

	mf_align_core u_core (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(cfg.align),
		.sysref(sysref),
		.sync_n(sync_n),
		.frame_strobe(frame_strobe),
		.sample_data(sample_data),
		.lane_data(lane_data),
		.k28_5_active(k28_5_active),
		.ilas_active(ilas_active),
		.data_active(data_active),
		.mf_boundary(mf_boundary)
	);
endmodule // serial_link_multiframe_control
`default_nettype wire

// *** verif/serial_link_multiframe_control_checker.sv ***
`default_nettype none
module serial_link_multiframe_control_checker
	import mf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sync_n,
	input wire logic frame_strobe,
	input wire logic decimate_by2,
	input wire logic [DATA_W-1:0] sample_data,
	input wire logic [DATA_W-1:0] lane_data,
	input wire logic k28_5_active,
	input wire logic ilas_active,
	input wire logic data_active,
	input wire logic mf_boundary,
	input wire logic scrambler_on,
	input wire logic [7:0] chan_a_lane_map,
	input wire logic [7:0] chan_b_lane_map,
	input wire logic [LANES*6-1:0] lane_deemphasis_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic therm_ok;
	always_comb begin
		therm_ok = 1'b1;
		for (int l = 0; l < LANES; l++) begin
			if ((lane_deemphasis_sel[6*l+:6] & (lane_deemphasis_sel[6*l+:6] + 6'h01)) != 6'h00)
				therm_ok = 1'b0;
		end
	end
	property p_state_excl;
		$onehot0({k28_5_active, ilas_active, data_active});
	endproperty
	a_state_excl: assert property (p_state_excl) else $error("link phases overlap");
	property p_sync_drop;
		!sync_n |-> ##[1:2] k28_5_active;
	endproperty
	a_sync_drop: assert property (p_sync_drop) else $error("no K28.5 after sync request");
	property p_lane_hold;
		!frame_strobe |=> $stable(lane_data);
	endproperty
	a_lane_hold: assert property (p_lane_hold) else $error("lane word moved off frame");
	property p_bound_cause;
		mf_boundary |-> $past(frame_strobe);
	endproperty
	a_bound_cause: assert property (p_bound_cause) else $error("boundary without frame");
	property p_bound_single;
		mf_boundary |=> !mf_boundary;
	endproperty
	a_bound_single: assert property (p_bound_single) else $error("boundary too long");
	property p_ilas_cause;
		$rose(ilas_active) |-> $past(frame_strobe) || $past(frame_strobe, 2);
	endproperty
	a_ilas_cause: assert property (p_ilas_cause) else $error("alignment off frame");
	property p_data_after;
		$rose(data_active) |-> $past(ilas_active);
	endproperty
	a_data_after: assert property (p_data_after) else $error("data without alignment");
	property p_plain;
		data_active && sync_n && frame_strobe && !scrambler_on && !decimate_by2
			&& !$past(decimate_by2)
			|=> lane_data == $past(sample_data);
	endproperty
	a_plain: assert property (p_plain) else $error("plain data altered");
	property p_map_default;
		!decimate_by2 && $stable(decimate_by2) |=>
			{chan_a_lane_map, chan_b_lane_map} == {MAP_IDENTITY, MAP_IDENTITY};
	endproperty
	a_map_default: assert property (p_map_default) else $error("map not default");
	property p_therm;
		therm_ok;
	endproperty
	a_therm: assert property (p_therm) else $error("de-emphasis not thermometer");
endmodule // serial_link_multiframe_control_checker
bind serial_link_multiframe_control serial_link_multiframe_control_checker i_checker (
	.aclk(aclk), .aresetn(aresetn), .sync_n(sync_n), .frame_strobe(frame_strobe),
	.decimate_by2(decimate_by2), .sample_data(sample_data), .lane_data(lane_data),
	.k28_5_active(k28_5_active), .ilas_active(ilas_active), .data_active(data_active),
	.mf_boundary(mf_boundary), .scrambler_on(scrambler_on),
	.chan_a_lane_map(chan_a_lane_map), .chan_b_lane_map(chan_b_lane_map),
	.lane_deemphasis_sel(lane_deemphasis_sel)
);
`default_nettype wire

// *** verif/jesd_rx_model.sv ***
`default_nettype none
module jesd_rx_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic frame_strobe,
	input wire logic [15:0] lane_data,
	input wire logic resync,
	output logic sync_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] k_seen_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			k_seen_reg <= 2'h0;
			sync_n <= 1'b0;
		end else if (frame_strobe && lane_data == 16'hBCBC && !sync_n) begin
			// Two K28.5 frames give code group sync
			k_seen_reg <= k_seen_reg + 2'h1;
			if (k_seen_reg == 2'h1)
				sync_n <= 1'b1;
		end
	end
endmodule // jesd_rx_model
`default_nettype wire

// *** verif/serial_link_multiframe_control_test.sv ***
`default_nettype none
module serial_link_multiframe_control_test import mf_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] RIDX [9] = '{7'h03, 7'h02, 7'h05, 7'h06, 7'h07, 7'h31, 7'h32, 7'h12, 7'h15};
	localparam logic [7:0] RVAL [9] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
	logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
	logic rready = '0, sysref = '0, frame_strobe = '0, decimate_by2 = '0, resync = '0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] sample_data = '0, lane_data;
	logic awready, wready, bvalid, arready, rvalid, sync_n, k28_5_active, ilas_active;
	logic data_active, mf_boundary, scrambler_on, subclass1;
	logic [1:0] bresp, rresp, fdiv = '0;
	logic [31:0] wdata = '0, rdata, rd_val, lfsr_a = 32'hDE6297C7, lfsr_b = 32'hDE6297C7;
	logic [7:0] chan_a_lane_map, chan_b_lane_map;
	logic [LANES*6-1:0] lane_deemphasis_sel;
	logic [1:0] exp_b [$];
	logic [65:0] exp_r [$];
	logic [65:0] nr;
	logic [15:0] lane_prev = '0, samp_prev = '0;
	logic sc1 = '0, sc2 = '0;
	int n_errors = 0, checked = 0;
	serial_link_multiframe_control i_serial_link_multiframe_control (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sysref, .sync_n,
		.frame_strobe, .decimate_by2, .sample_data, .lane_data, .k28_5_active, .ilas_active,
		.data_active, .mf_boundary, .scrambler_on, .subclass1, .chan_a_lane_map,
		.chan_b_lane_map, .lane_deemphasis_sel);
	jesd_rx_model i_jesd_rx_model (.aclk, .aresetn, .frame_strobe, .lane_data, .resync, .sync_n);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Self-synchronous descrambler, state is the last 15 lane bits
	function automatic logic [15:0] descr(input logic [15:0] o, input logic [14:0] s);
		logic [14:0] st;
		logic [15:0] d;
		st = s;
		d = '0;
		for (int i = 15; i >= 0; i--) begin
			d[i] = o[i] ^ st[14] ^ st[13];
			st = {st[13:0], o[i]};
		end
		return d;
	endfunction
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		if (exp_b.size() != 0 || exp_r.size() != 0)
			n_errors++;
		$display("errors %0d comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] e);
		int t;
		t = 0;
		exp_b.push_back(e);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid && t < 500);
		if (!bvalid)
			n_errors++;
		bready <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic rd(input logic [6:0] idx, input logic [31:0] m, input logic [33:0] e);
		int t;
		t = 0;
		exp_r.push_back({m, e[33:32], e[31:0] & m});
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid && t < 500);
		if (!rvalid)
			n_errors++;
		rd_val = rdata;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic pulse();
		@(posedge aclk);
		sysref <= 1'b1;
		resync <= 1'b1;
		@(posedge aclk);
		resync <= 1'b0;
		@(posedge aclk);
		sysref <= 1'b0;
	endtask
	task automatic count_to(input bit which, output int n);
		int t;
		n = 0;
		t = 0;
		do begin
			@(posedge aclk);
			t++;
			if (mf_boundary)
				n++;
		end while (!(which ? data_active : ilas_active) && t < 2000);
	endtask
	initial begin
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		fdiv <= fdiv + 2'h1;
		frame_strobe <= (fdiv == 2'h3);
		if (fdiv == 2'h3) begin
			lfsr_a = lfsr(lfsr_a);
			sample_data <= lfsr_a[15:0];
		end
		if (frame_strobe) begin
			if (sc1 && sc2)
				chk(34'(descr(lane_data, lane_prev[14:0])), 34'(samp_prev));
			sc2 = sc1;
			sc1 = data_active && sync_n && scrambler_on;
			lane_prev = lane_data;
			samp_prev = sample_data;
		end
		if (bvalid && bready && exp_b.size() > 0)
			chk(34'(bresp), 34'(exp_b.pop_front()));
		if (rvalid && rready && exp_r.size() > 0) begin
			nr = exp_r.pop_front();
			chk({rresp, rdata & nr[65:34]}, nr[33:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		final_report();
	end
	initial begin
		int n, g;
		logic [6:0] t7;
		logic [4:0] v;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(34'({subclass1, scrambler_on, chan_a_lane_map, chan_b_lane_map}), 34'h2E4E4);
		for (int i = 0; i < 9; i++)
			rd(RIDX[i], 32'hFF, {RESP_OKAY, 24'h0, RVAL[i]});
		rd(7'h10, 32'hFFFFFFFF, {RESP_SLVERR, 32'h0});
		wr(7'h10, 8'h01, RESP_SLVERR);
		wr(IDX_MF_LEN, 8'h03, RESP_OKAY);
		rd(IDX_MF_LEN, 32'hFF, {RESP_OKAY, 32'h03});
		g = 0;
		while (!mf_boundary) @(posedge aclk);
		do begin
			@(posedge aclk);
			g++;
		end while (!mf_boundary && g < 100);
		chk(34'(g), 34'h10);
		for (int l = 0; l < LANES; l++) begin
			lfsr_b = lfsr(lfsr_b);
			t7 = (7'h01 << (lfsr_b[7:0] % 8'h07)) - 7'h01;
			wr(IDX_DEEMPH[l], {t7[5:0], 2'h0}, RESP_OKAY);
			wr(IDX_DEEMPH[l], 8'h14, RESP_OKAY);
			chk(34'(lane_deemphasis_sel[6*l+:6]), 34'(t7[5:0]));
			rd(IDX_DEEMPH[l], 32'hFF, {RESP_OKAY, 24'h0, t7[5:0], 2'h0});
		end
		decimate_by2 <= 1'b1;
		wr(IDX_MAP_A, 8'h1B, RESP_OKAY);
		wr(IDX_MAP_B, 8'h4E, RESP_OKAY);
		wr(IDX_MAP_A, 8'h05, RESP_OKAY);
		chk(34'({chan_a_lane_map, chan_b_lane_map}), 34'h1B4E);
		rd(IDX_MAP_A, 32'hFF, {RESP_OKAY, 32'h1B});
		decimate_by2 <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(IDX_MF_CTRL, i ? 8'h74 : 8'hF4, RESP_OKAY);
			pulse();
			rd(IDX_STATUS, 32'h1F, {RESP_OKAY, i ? 32'h0 : 32'h1D});
		end
		for (int d = 0; d < 4; d++) begin
			wr(IDX_MF_CTRL, 8'hF4 | 8'(d), RESP_OKAY);
			pulse();
			count_to(1'b0, n);
			chk(34'(n), 34'(2 + d));
			count_to(1'b1, n);
			chk(34'(n), 34'h4);
		end
		repeat (40) @(posedge aclk);
		wr(IDX_SCRAMBLE, 8'h80, RESP_OKAY);
		chk(34'(scrambler_on), 34'h1);
		repeat (40) @(posedge aclk);
		for (int i = 0; i < 2; i++) begin
			wr(i ? IDX_SUBCLASS : IDX_RESET_MASK, i ? 8'h00 : 8'h08, RESP_OKAY);
			chk(34'(subclass1), 34'(i == 0));
			rd(IDX_STATUS, 32'h0, {RESP_OKAY, 32'h0});
			v = rd_val[4:0] ^ 5'h10;
			wr(IDX_MF_CTRL, {1'b1, v, 2'h0}, RESP_OKAY);
			pulse();
			rd(IDX_STATUS, 32'h0, {RESP_OKAY, 32'h0});
			chk(34'(rd_val[4:0] != v), 34'h1);
			wr(i ? IDX_SUBCLASS : IDX_RESET_MASK, i ? 8'h08 : 8'h00, RESP_OKAY);
		end
		final_report();
	end
endmodule // serial_link_multiframe_control_test
`default_nettype wire
